// ---- shared/dcs_pkg.sv ----
package dcs_pkg;

    // register byte offsets
    localparam logic [7:0] ADR_CMD_SRC   = 8'h00;
    localparam logic [7:0] ADR_TERM_FUNC = 8'h04;
    localparam logic [7:0] ADR_KEY_CFG   = 8'h08;
    localparam logic [7:0] ADR_SER_CFG   = 8'h0C;
    localparam logic [7:0] ADR_STATUS    = 8'h10;

    // field positions
    localparam int TERM_FUNC_W    = 6;
    localparam int KEY_PWR_RUN    = 8;
    localparam int SER_PROTO_LSB  = 8;
    localparam int SER_BAUD_LSB   = 16;

    // reset values
    localparam logic [2:0]  CMD_SRC_RST  = 3'h0;
    localparam logic [29:0] TERM_FUNC_RST = 30'h0000_0000;
    localparam logic [1:0]  KEY_FUNC_RST = 2'h0;
    localparam logic [7:0]  STATION_RST  = 8'h01;
    localparam logic [1:0]  PROTO_RST    = 2'h0;
    localparam logic [2:0]  BAUD_RST     = 3'h3;

    // legal ranges
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hFA;
    localparam logic [1:0] PROTO_MAX   = 2'h2;
    localparam logic [1:0] KEY_FUNC_MAX = 2'h2;
    localparam logic [1:0] KEY_FUNC_LOCAL_REMOTE = 2'h2;

    // terminal function codes
    localparam logic [5:0] FUNC_FWD     = 6'h01;
    localparam logic [5:0] FUNC_REV     = 6'h02;
    localparam logic [5:0] FUNC_RUN_EN  = 6'h0D;
    localparam logic [5:0] FUNC_JOG_FWD = 6'h28;
    localparam logic [5:0] FUNC_JOG_REV = 6'h29;
    localparam logic [5:0] FUNC_PREEXC  = 6'h2A;

    // indicator flash half period
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned FLASH_MS     = 250;
    localparam int unsigned FLASH_CYCLES = CLK_MHZ * 1000 * FLASH_MS;

    typedef enum logic [2:0] {
        SRC_KEYPAD               = 3'h0,
        SRC_TWO_WIRE_FWD_REV_MODE = 3'h1,
        SRC_TWO_WIRE_RUN_DIR_MODE = 3'h2,
        SRC_SERIAL               = 3'h3
    } dcs_src_t;

    typedef enum logic [1:0] {
        MODE_REMOTE = 2'b01,
        MODE_LOCAL  = 2'b10
    } dcs_mode_t;

    typedef struct packed {
        logic [7:0] station;
        logic       run;
        logic       reverse;
    } dcs_serial_cmd_t;

endpackage

// ---- hw/dcs_cmd_select.sv ----
// The Wishbone interface to the registers and the register offsets were decided locally.
module dcs_cmd_select #(
    parameter int unsigned FLASH_CYCLES = dcs_pkg::FLASH_CYCLES
) (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    // wishbone slave
    input  wire logic                    wb_cyc_in,
    input  wire logic                    wb_stb_in,
    input  wire logic                    wb_we_in,
    input  wire logic [7:0]              wb_adr_in,
    input  wire logic [3:0]              wb_sel_in,
    input  wire logic [31:0]             wb_dat_in,
    output logic      [31:0]             wb_dat_out,
    output logic                         wb_ack_out,
    // terminal and keypad pins
    input  wire logic [4:0]              input_terminals_one_to_five_in,
    input  wire logic                    run_key_in,
    input  wire logic                    stop_key_in,
    input  wire logic                    jog_key_in,
    input  wire logic                    mode_toggle_key_in,
    // serial engine and fault logic, same clock
    input  wire logic                    serial_valid_in,
    input  wire dcs_pkg::dcs_serial_cmd_t serial_cmd_in,
    input  wire logic                    fault_reset_in,
    // drive commands
    output logic                         drive_run_out,
    output logic                         drive_reverse_out,
    output logic                         drive_jog_out,
    output logic                         pre_excite_out,
    output logic                         local_indicator_out,
    output logic                         remote_mode_out
);

    logic [8:0]  sync1_q, sync2_q, prev_q;
    logic [2:0]  cmd_src_q;
    logic [29:0] term_func_q;
    logic [1:0]  key_func_q;
    logic        pwr_run_q;
    logic [7:0]  station_q;
    logic [1:0]  proto_q;
    logic [2:0]  baud_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    dcs_pkg::dcs_mode_t mode_q;
    logic        key_run_q, ser_run_q, ser_rev_q, armed_q, fault_lock_q;
    logic        run_q, rev_q, jog_q, pre_q, ind_q, flash_q, remote_q;
    logic [31:0] flash_cnt_q;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            prev_q  <= 9'h000;
        end else begin
            sync1_q <= {mode_toggle_key_in, jog_key_in, stop_key_in,
                        run_key_in, input_terminals_one_to_five_in};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    logic [4:0] term_s;
    logic       run_edge, stop_edge, jog_s, toggle_edge;
    assign term_s      = sync2_q[4:0];
    assign run_edge    = sync2_q[5] & ~prev_q[5];
    assign stop_edge   = sync2_q[6] & ~prev_q[6];
    assign jog_s       = sync2_q[7];
    assign toggle_edge = sync2_q[8] & ~prev_q[8];

    // map terminals to roles by function code
    logic fx_s, rx_s, run_en_s, jogf_s, jogr_s, pre_s;
    always_comb begin
        logic [5:0] code;
        code     = 6'h00;
        fx_s     = 1'b0;
        rx_s     = 1'b0;
        run_en_s = 1'b0;
        jogf_s   = 1'b0;
        jogr_s   = 1'b0;
        pre_s    = 1'b0;
        for (int i = 0; i < 5; i++) begin
            code = term_func_q[i*dcs_pkg::TERM_FUNC_W +: dcs_pkg::TERM_FUNC_W];
            fx_s     |= term_s[i] & (code == dcs_pkg::FUNC_FWD);
            rx_s     |= term_s[i] & (code == dcs_pkg::FUNC_REV);
            run_en_s |= term_s[i] & (code == dcs_pkg::FUNC_RUN_EN);
            jogf_s   |= term_s[i] & (code == dcs_pkg::FUNC_JOG_FWD);
            jogr_s   |= term_s[i] & (code == dcs_pkg::FUNC_JOG_REV);
            pre_s    |= term_s[i] & (code == dcs_pkg::FUNC_PREEXC);
        end
    end

    // ack one cycle after the strobe; a write lands at the edge that
    // samples ack, so the master's view and the register agree
    logic        req, wr;
    logic [31:0] wmask, wmerge;
    assign req   = wb_cyc_in & wb_stb_in & ~ack_q;
    assign wr    = wb_cyc_in & wb_stb_in & wb_we_in & ack_q;
    assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                    {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    logic wr_src, wr_term, wr_key, wr_ser;
    assign wr_src  = wr & (wb_adr_in == dcs_pkg::ADR_CMD_SRC);
    assign wr_term = wr & (wb_adr_in == dcs_pkg::ADR_TERM_FUNC);
    assign wr_key  = wr & (wb_adr_in == dcs_pkg::ADR_KEY_CFG);
    assign wr_ser  = wr & (wb_adr_in == dcs_pkg::ADR_SER_CFG);

    logic [31:0] key_old, ser_old, key_new, ser_new;
    assign key_old = {23'h00_0000, pwr_run_q, 6'h00, key_func_q};
    assign ser_old = {13'h0000, baud_q, 6'h00, proto_q, station_q};
    assign key_new = (key_old & ~wmask) | (wb_dat_in & wmask);
    assign ser_new = (ser_old & ~wmask) | (wb_dat_in & wmask);
    assign wmerge  = ({2'h0, term_func_q} & ~wmask) | (wb_dat_in & wmask);

    logic key_func_wr;
    assign key_func_wr = wr_key & (key_new[1:0] <= dcs_pkg::KEY_FUNC_MAX);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_src_q   <= dcs_pkg::CMD_SRC_RST;
            term_func_q <= dcs_pkg::TERM_FUNC_RST;
            key_func_q  <= dcs_pkg::KEY_FUNC_RST;
            pwr_run_q   <= 1'b0;
            station_q   <= dcs_pkg::STATION_RST;
            proto_q     <= dcs_pkg::PROTO_RST;
            baud_q      <= dcs_pkg::BAUD_RST;
        end else begin
            if (wr_src && wb_sel_in[0])
                cmd_src_q <= wb_dat_in[2:0];
            if (wr_term)
                term_func_q <= wmerge[29:0];
            if (key_func_wr)
                key_func_q <= key_new[1:0];
            if (wr_key)
                pwr_run_q <= key_new[dcs_pkg::KEY_PWR_RUN];
            if (wr_ser && ser_new[7:0] >= dcs_pkg::STATION_MIN
                && ser_new[7:0] <= dcs_pkg::STATION_MAX)
                station_q <= ser_new[7:0];
            if (wr_ser && ser_new[9:8] <= dcs_pkg::PROTO_MAX)
                proto_q <= ser_new[dcs_pkg::SER_PROTO_LSB +: 2];
            if (wr_ser)
                baud_q <= ser_new[dcs_pkg::SER_BAUD_LSB +: 3];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req) begin
                unique case (wb_adr_in)
                    dcs_pkg::ADR_CMD_SRC:   rdat_q <= {29'h0, cmd_src_q};
                    dcs_pkg::ADR_TERM_FUNC: rdat_q <= {2'h0, term_func_q};
                    dcs_pkg::ADR_KEY_CFG:   rdat_q <= key_old;
                    dcs_pkg::ADR_SER_CFG:   rdat_q <= ser_old;
                    dcs_pkg::ADR_STATUS:
                        rdat_q <= {24'h00_0000, fault_lock_q, armed_q,
                                   mode_q == dcs_pkg::MODE_LOCAL,
                                   pre_q, jog_q, rev_q, run_q, ind_q};
                    default:                rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    // mode switching
    logic toggle_ev, is_local, src_terminal;
    assign toggle_ev = toggle_edge
                       & (key_func_q == dcs_pkg::KEY_FUNC_LOCAL_REMOTE);
    assign is_local  = (mode_q == dcs_pkg::MODE_LOCAL);
    assign src_terminal =
        (cmd_src_q == dcs_pkg::SRC_TWO_WIRE_FWD_REV_MODE)
        | (cmd_src_q == dcs_pkg::SRC_TWO_WIRE_RUN_DIR_MODE);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_q <= dcs_pkg::MODE_REMOTE;
        end else if (fault_reset_in) begin
            mode_q <= dcs_pkg::MODE_LOCAL;
        end else if (key_func_wr
                     && key_new[1:0] == dcs_pkg::KEY_FUNC_LOCAL_REMOTE) begin
            mode_q <= dcs_pkg::MODE_REMOTE;
        end else if (toggle_ev) begin
            unique case (mode_q)
                dcs_pkg::MODE_REMOTE: mode_q <= dcs_pkg::MODE_LOCAL;
                dcs_pkg::MODE_LOCAL:  mode_q <= dcs_pkg::MODE_REMOTE;
            endcase
        end
    end

    // keypad run latch; stop wins over run for safety
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_run_q <= 1'b0;
        end else if (fault_reset_in || toggle_ev || stop_edge) begin
            key_run_q <= 1'b0;
        end else if (run_edge
                     && (is_local || cmd_src_q == dcs_pkg::SRC_KEYPAD)) begin
            key_run_q <= 1'b1;
        end
    end

    // serial commands only in serial source
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ser_run_q <= 1'b0;
            ser_rev_q <= 1'b0;
        end else if (fault_reset_in || toggle_ev) begin
            // serial run latch cleared on mode toggle or fault reset
            ser_run_q <= 1'b0;
        end else if (serial_valid_in && !is_local
                     && cmd_src_q == dcs_pkg::SRC_SERIAL
                     && serial_cmd_in.station == station_q) begin
            ser_run_q <= serial_cmd_in.run;
            ser_rev_q <= serial_cmd_in.reverse;
        end
    end

    // terminal arming after power-up or fault reset
    logic cmd_terms_off;
    assign cmd_terms_off = ~(fx_s | rx_s | jogf_s | jogr_s | pre_s);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            armed_q      <= 1'b0;
            fault_lock_q <= 1'b0;
        end else if (fault_reset_in) begin
            armed_q      <= 1'b0;
            fault_lock_q <= 1'b1;
        end else if (!armed_q) begin
            if (fault_lock_q) begin
                if (term_s == 5'h00) begin
                    armed_q      <= 1'b1;
                    fault_lock_q <= 1'b0;
                end
            // off then on unless power-on run
            end else if (cmd_terms_off || pwr_run_q) begin
                armed_q <= 1'b1;
            end
        end
    end

    // command selection
    logic run_d, rev_d, jog_d, pre_d;
    always_comb begin
        run_d = 1'b0;
        rev_d = 1'b0;
        jog_d = 1'b0;
        pre_d = 1'b0;
        if (is_local) begin
            run_d = key_run_q;
            // local jog gated by run enable
            jog_d = jog_s & run_en_s;
        end else begin
            jog_d = armed_q & (jogf_s ^ jogr_s);
            pre_d = armed_q & pre_s;
            rev_d = armed_q & jogr_s & ~jogf_s;
            unique case (cmd_src_q)
                dcs_pkg::SRC_KEYPAD: run_d = key_run_q;
                dcs_pkg::SRC_TWO_WIRE_FWD_REV_MODE: begin
                    run_d = armed_q & (fx_s ^ rx_s);
                    rev_d = armed_q & rx_s & ~fx_s;
                end
                dcs_pkg::SRC_TWO_WIRE_RUN_DIR_MODE: begin
                    run_d = armed_q & fx_s;
                    rev_d = armed_q & fx_s & rx_s;
                end
                dcs_pkg::SRC_SERIAL: begin
                    run_d = ser_run_q;
                    rev_d = ser_run_q & ser_rev_q;
                end
                default: run_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flash_cnt_q <= 32'h0000_0000;
            flash_q     <= 1'b0;
        end else if (!is_local) begin
            flash_cnt_q <= 32'h0000_0000;
            flash_q     <= 1'b1;
        end else if (flash_cnt_q >= FLASH_CYCLES - 1) begin
            flash_cnt_q <= 32'h0000_0000;
            flash_q     <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            run_q <= 1'b0;
            rev_q <= 1'b0;
            jog_q <= 1'b0;
            pre_q <= 1'b0;
            ind_q <= 1'b0;
            remote_q <= 1'b1;
        end else begin
            run_q <= run_d;
            rev_q <= rev_d;
            jog_q <= jog_d;
            pre_q <= pre_d;
            ind_q <= is_local & flash_q;
            remote_q <= ~is_local;
        end
    end
    assign drive_run_out       = run_q;
    assign drive_reverse_out   = rev_q;
    assign drive_jog_out       = jog_q;
    assign pre_excite_out      = pre_q;
    assign local_indicator_out = ind_q;
    assign remote_mode_out     = remote_q;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_toggle_plain;
        toggle_ev && !fault_reset_in && !key_func_wr;
    endsequence
    sequence s_stopped_after;
        ##1 !drive_run_out;
    endsequence

    AST_TO_LOCAL_STOPS: assert property (
        (mode_q == dcs_pkg::MODE_REMOTE) ##0 s_toggle_plain |=>
        is_local ##0 s_stopped_after) else $error("local switch no stop");
    AST_TO_REMOTE_IND: assert property (
        is_local ##0 s_toggle_plain |=> !is_local ##1 !local_indicator_out)
        else $error("indicator not off in remote");
    AST_ENABLE_REMOTE: assert property (
        key_func_wr && key_new[1:0] == dcs_pkg::KEY_FUNC_LOCAL_REMOTE
        && !fault_reset_in |=> mode_q == dcs_pkg::MODE_REMOTE)
        else $error("enable did not enter remote");
    AST_BOTH_STOP: assert property (
        !is_local && cmd_src_q == dcs_pkg::SRC_TWO_WIRE_FWD_REV_MODE
        && fx_s == rx_s |=> !drive_run_out) else $error("equal terms ran");
    AST_RUN_DIR: assert property (
        !is_local && cmd_src_q == dcs_pkg::SRC_TWO_WIRE_RUN_DIR_MODE
        && armed_q && fx_s |=> drive_run_out
        && drive_reverse_out == $past(rx_s)) else $error("run/dir wrong");
    AST_SERIAL_ONLY: assert property (
        !is_local && cmd_src_q == dcs_pkg::SRC_SERIAL
        |=> drive_run_out == $past(ser_run_q)) else $error("serial run");
    AST_STATION: assert property (
        serial_valid_in && serial_cmd_in.station != station_q
        && !fault_reset_in && !toggle_ev |=> $stable(ser_run_q))
        else $error("foreign station accepted");
    AST_FAULT_LOCAL: assert property (
        fault_reset_in |=> is_local && !armed_q && fault_lock_q)
        else $error("fault reset not local");
    AST_UNARMED: assert property (
        !armed_q && !is_local && src_terminal |=> !drive_run_out)
        else $error("unarmed terminal ran");
    AST_LOCAL_JOG: assert property (
        is_local && !run_en_s |=> !drive_jog_out) else $error("jog gated");
    AST_STOP_KEY: assert property (
        stop_edge |=> !key_run_q ##1 !is_local
        || cmd_src_q != dcs_pkg::SRC_KEYPAD || !drive_run_out
        || key_run_q) else $error("stop key ignored");

endmodule

// ---- verification/dcs_far_side.sv ----
module dcs_far_side (
    // clock
    input  wire logic                     clk_in,
    // terminal contacts and keypad keys
    output logic [4:0]                    terms_out,
    output logic [3:0]                    keys_out,
    // upper-level serial controller
    output logic                          serial_valid_out,
    output dcs_pkg::dcs_serial_cmd_t      serial_cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        terms_out = 5'h00;
        keys_out = 4'h0;
        serial_valid_out = 1'b0;
        serial_cmd_out = '0;
    end

    task automatic set_terms(input logic [4:0] v);
        @(posedge clk_in);
        terms_out <= v;
    endtask

    // keys: bit 0 run, 1 stop, 2 jog, 3 mode toggle
    task automatic set_keys(input logic [3:0] v);
        @(posedge clk_in);
        keys_out <= v;
    endtask

    // held long enough to clear the input synchronisers
    task automatic press(input int k);
        set_keys(4'h1 << k);
        repeat (6) @(posedge clk_in);
        keys_out <= 4'h0;
    endtask

    // command lines are scrambled once the frame is gone, never left valid
    task automatic send_frame(input logic [7:0] st, input logic run,
                              input logic rev);
        @(posedge clk_in);
        serial_valid_out <= 1'b1;
        serial_cmd_out <= '{station: st, run: run, reverse: rev};
        @(posedge clk_in);
        serial_valid_out <= 1'b0;
        serial_cmd_out <= ~serial_cmd_out;
    endtask
endmodule

// ---- verification/test_drive_command_source_select.sv ----
module test_drive_command_source_select;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk_in, rstn_in, fault_reset;
    logic                     wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]               wb_adr;
    logic [3:0]               wb_sel, keys;
    logic [31:0]              wb_dat_w, wb_dat_r, rd;
    logic [4:0]               terms;
    logic                     ser_valid, drv_run, drv_rev, drv_jog;
    logic                     pre_exc, ind, remote;
    dcs_pkg::dcs_serial_cmd_t ser_cmd;
    int                       miscompares, samples_checked, seed, i, ones;
    logic [1:0]               fr, e;
    logic [2:0]               src;
    logic [31:0]              ser_exp, wd;
    logic [7:0]               st, wa;
    logic [3:0]               ws;

    dcs_far_side fs_u (.clk_in(clk_in), .terms_out(terms), .keys_out(keys),
        .serial_valid_out(ser_valid), .serial_cmd_out(ser_cmd));

    dcs_cmd_select #(.FLASH_CYCLES(4)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc),
        .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r),
        .wb_ack_out(wb_ack), .input_terminals_one_to_five_in(terms),
        .run_key_in(keys[0]), .stop_key_in(keys[1]), .jog_key_in(keys[2]),
        .mode_toggle_key_in(keys[3]), .serial_valid_in(ser_valid),
        .serial_cmd_in(ser_cmd), .fault_reset_in(fault_reset),
        .drive_run_out(drv_run), .drive_reverse_out(drv_rev),
        .drive_jog_out(drv_jog), .pre_excite_out(pre_exc),
        .local_indicator_out(ind), .remote_mode_out(remote));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, input logic [3:0] sel = 4'hf);
        int n;
        @(posedge clk_in);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, we, adr, dat};
        wb_sel <= sel;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end else begin
            rd = wb_dat_r;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
        end
    endtask

    // pin changes need the synchroniser depth before outputs follow
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    function automatic logic [1:0] exp_wire(input logic [2:0] s,
                                             input logic f, input logic r);
        if (s == 3'h1) exp_wire = {f ^ r, r & ~f};
        else exp_wire = {f, f & r};
    endfunction

    // only fields whose merged value is legal take it
    function automatic logic [31:0] exp_ser(input logic [31:0] o, d,
                                            input logic [3:0] s);
        logic [31:0] m, n;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        n = (o & ~m) | (d & m);
        exp_ser = o;
        if (n[7:0] >= dcs_pkg::STATION_MIN
            && n[7:0] <= dcs_pkg::STATION_MAX)
            exp_ser[7:0] = n[7:0];
        if (n[9:8] <= dcs_pkg::PROTO_MAX) exp_ser[9:8] = n[9:8];
        exp_ser[18:16] = n[18:16];
    endfunction

    task automatic toggle_mode;
        fs_u.press(3);
        wait_cyc(6);
    endtask

    initial begin
        repeat (100000) @(posedge clk_in);
        miscompares++;
        print_verdict();
    end

    initial begin
        {rstn_in, fault_reset, wb_cyc, wb_stb, wb_we} = 5'b0;
        {wb_adr, wb_sel, wb_dat_w} = '0;
        miscompares = 0;
        samples_checked = 0;
        seed = 75;
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        wait_cyc(2);
        check("remote_after_reset", remote, 32'h0000_0001);
        wb(1'b0, dcs_pkg::ADR_SER_CFG, 32'h0000_0000);
        check("ser_cfg_reset", rd, 32'h0003_0001);
        wb(1'b0, 8'h14, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        wa = 8'h80 | 8'($random(seed));
        wb(1'($random(seed)), wa, $random(seed));
        check("unmapped_rand", rd, 32'h0000_0000);
        // out-of-range station and protocol are held, baud 7 accepted
        wb(1'b1, dcs_pkg::ADR_SER_CFG, 32'h0007_03FB);
        wb(1'b0, dcs_pkg::ADR_SER_CFG, 32'h0000_0000);
        check("ser_cfg_range", rd, 32'h0007_0001);
        wb(1'b1, dcs_pkg::ADR_SER_CFG, 32'h0000_02FA);
        wb(1'b0, dcs_pkg::ADR_SER_CFG, 32'h0000_0000);
        check("ser_cfg_max", rd, 32'h0000_02FA);
        ser_exp = 32'h0000_02FA;
        repeat (8) begin
            wd = $random(seed);
            ws = 4'($random(seed));
            wb(1'b1, dcs_pkg::ADR_SER_CFG, wd, ws);
            ser_exp = exp_ser(ser_exp, wd, ws);
            wb(1'b0, dcs_pkg::ADR_SER_CFG, 32'h0000_0000);
            check("ser_cfg_rand", rd, ser_exp);
        end
        wb(1'b1, dcs_pkg::ADR_SER_CFG, 32'h0003_0001);
        wb(1'b1, dcs_pkg::ADR_KEY_CFG, 32'h0000_0002);
        wait_cyc(2);
        check("remote_on_key_func", remote, 32'h0000_0001);
        fs_u.press(0);
        wait_cyc(6);
        check("keypad_run", drv_run, 32'h0000_0001);
        fs_u.press(1);
        wait_cyc(6);
        check("keypad_stop", drv_run, 32'h0000_0000);
        // P1 run enable, P2 forward, P4 reverse
        wb(1'b1, dcs_pkg::ADR_TERM_FUNC, {2'b00, 6'h00, dcs_pkg::FUNC_REV,
            6'h00, dcs_pkg::FUNC_FWD, dcs_pkg::FUNC_RUN_EN});
        // toggle disabled: random keys must not disturb terminal control
        wb(1'b1, dcs_pkg::ADR_KEY_CFG, 32'h0000_0000);
        for (i = 0; i < 24; i++) begin
            src = (i < 12) ? 3'h1 : 3'h2;
            if (i % 12 == 0) wb(1'b1, dcs_pkg::ADR_CMD_SRC, {29'h0, src});
            fr = (i % 12 < 4) ? i[1:0] : 2'($random(seed));
            fs_u.set_keys(4'($random(seed)));
            fs_u.set_terms({1'b0, fr[0], 1'b0, fr[1], 1'b0});
            wait_cyc(6);
            e = exp_wire(src, fr[1], fr[0]);
            check("wire_run", drv_run, {31'h0, e[1]});
            if (e[1]) check("wire_rev", drv_rev, {31'h0, e[0]});
            check("wire_jog", drv_jog, 32'h0000_0000);
        end
        fs_u.set_keys(4'h0);
        wb(1'b1, dcs_pkg::ADR_KEY_CFG, 32'h0000_0002);
        wb(1'b1, dcs_pkg::ADR_CMD_SRC, 32'h0000_0001);
        fs_u.set_terms(5'b00010);
        wait_cyc(6);
        toggle_mode();
        check("local_stop", {remote, drv_run}, 32'h0000_0000);
        ones = 0;
        repeat (12) begin
            @(posedge clk_in);
            ones += int'(ind === 1'b1);
        end
        check("flash", {ones > 0, ones < 12}, 32'h0000_0003);
        fs_u.set_keys(4'h4);
        wait_cyc(6);
        check("jog_no_enable", drv_jog, 32'h0000_0000);
        fs_u.set_terms(5'b00011);
        wait_cyc(6);
        check("jog_enabled", drv_jog, 32'h0000_0001);
        fs_u.set_keys(4'h0);
        fs_u.press(0);
        wait_cyc(6);
        check("local_run_key", drv_run, 32'h0000_0001);
        fs_u.set_terms(5'b01001);
        wait_cyc(6);
        toggle_mode();
        check("remote_terms", {ind, drv_run, drv_rev}, 32'h0000_0003);
        wb(1'b1, dcs_pkg::ADR_CMD_SRC, 32'h0000_0003);
        toggle_mode();
        fs_u.press(0);
        toggle_mode();
        check("digital_src_stop", drv_run, 32'h0000_0000);
        st = 8'($random(seed));
        if (st == dcs_pkg::STATION_RST) st = 8'h02;
        fs_u.send_frame(st, 1'b1, 1'b0);
        wait_cyc(4);
        check("foreign_station", drv_run, 32'h0000_0000);
        fs_u.send_frame(8'h01, 1'b1, 1'b1);
        wait_cyc(4);
        check("serial_run", {drv_run, drv_rev}, 32'h0000_0003);
        wb(1'b1, dcs_pkg::ADR_CMD_SRC, 32'h0000_0001);
        fs_u.set_terms(5'b00010);
        wait_cyc(6);
        @(posedge clk_in);
        fault_reset <= 1'b1;
        @(posedge clk_in);
        fault_reset <= 1'b0;
        wait_cyc(6);
        check("fault_local", {remote, drv_run}, 32'h0000_0000);
        toggle_mode();
        check("fault_unarmed", drv_run, 32'h0000_0000);
        fs_u.set_terms(5'b00000);
        wait_cyc(6);
        fs_u.set_terms(5'b00010);
        wait_cyc(6);
        check("fault_rearmed", drv_run, 32'h0000_0001);
        // P3 pre-excitation, P5 jog reverse
        wb(1'b1, dcs_pkg::ADR_TERM_FUNC, {2'b00, dcs_pkg::FUNC_JOG_REV,
            dcs_pkg::FUNC_REV, dcs_pkg::FUNC_PREEXC, dcs_pkg::FUNC_FWD,
            dcs_pkg::FUNC_RUN_EN});
        fs_u.set_terms(5'b10110);
        wait_cyc(6);
        check("pre_jog", {pre_exc, drv_jog, drv_run}, 32'h0000_0007);
        wb(1'b0, dcs_pkg::ADR_STATUS, 32'h0000_0000);
        check("status", rd, 32'h0000_005A);
        toggle_mode();
        wb(1'b1, dcs_pkg::ADR_KEY_CFG, 32'h0000_0002);
        wait_cyc(2);
        check("key_func_remote", remote, 32'h0000_0001);
        print_verdict();
    end
endmodule
